//--- pocfg_params.svh
// Constants for the port overcurrent configuration bank.
// Assumes inclusion by bare name from the package and the top module.
`ifndef POCFG_PARAMS_SVH
`define POCFG_PARAMS_SVH

// Register indices; byte address is four times the index
`define POCFG_IDX_SEL2 17'h03C24
`define POCFG_IDX_SEL3 17'h03C28
`define POCFG_IDX_SEL4 17'h03C2C
`define POCFG_IDX_CDP 17'h05246
`define POCFG_IDX_GANG 17'h0525A
`define POCFG_IDX_CHOICE 17'h0525B
`define POCFG_IDX_IRQ_STAT 17'h05300
`define POCFG_IDX_IRQ_MASK 17'h05301

// Field positions
`define POCFG_SEL_LSB 0
`define POCFG_SEL_MSB 3
`define POCFG_GANG_LSB 1
`define POCFG_GANG_MSB 4
`define POCFG_CHOICE_MSB 5
`define POCFG_IRQ_OC_LSB 0
`define POCFG_IRQ_CDP_LSB 4

// Selector codes
`define POCFG_SRC_OFF 4'h0
`define POCFG_SRC_PIN 4'h1
`define POCFG_SRC_GPIO 4'h2
`define POCFG_SRC_FORCE 4'hF

// Reset values
`define POCFG_RST_SEL 8'h00
`define POCFG_RST_CDP 8'h00
`define POCFG_RST_GANG 8'h00
`define POCFG_RST_CHOICE 8'h00
`define POCFG_RST_IRQ 8'h00

// Timing: read wait states
`define POCFG_RD_WAIT 1

`endif

//--- pocfg_pkg.sv
// Types for the port overcurrent configuration bank.
// Assumes pocfg_params.svh is on the include path.
`include "pocfg_params.svh"

package pocfg_pkg;

   typedef logic [16:0] pocfg_idx_t;

   // Captured AHB address phase
   typedef struct packed {
      logic valid;
      logic write;
      pocfg_idx_t idx;
   } pocfg_acc_s;

   // Per-port pin group, ports 4..1 in bits 3..0
   typedef struct packed {
      logic [3:0] sense;
      logic [3:0] gpio;
      logic [3:0] handshake;
   } pocfg_pins_s;

endpackage : pocfg_pkg

//--- pocfg_top.sv
// Overcurrent configuration and status registers for a four-port hub, AHB-Lite slave.
// Assumes one clock hclk, port inputs synchronous to it, single word transfers.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "pocfg_params.svh"

module pocfg_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Port side
   input wire pocfg_pkg::pocfg_pins_s port_pins,
   input wire logic enumerated,
   output logic [3:0] port_overcurrent,
   output logic [3:0] port_disabled,
   // Shared fault pin
   input wire logic shared_fault_in,
   output logic shared_fault_out,
   output logic shared_fault_oe,
   output logic [5:0] shared_fault_pin_choice,
   // Interrupt
   output logic irq
);
   import pocfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] sel_r [2:4];
   logic [7:0] cdp_r;
   logic [7:0] gang_r;
   logic [7:0] choice_r;
   logic [7:0] irq_stat_r;
   logic [7:0] irq_mask_r;
   pocfg_acc_s acc_r;
   logic rd_wait_r;

   logic [3:0] src [0:3];
   logic [3:0] raw_oc;
   logic [3:0] oc_nxt;
   logic [3:0] gang_en;
   logic gang_any;
   logic choice_ok;
   logic [7:0] irq_ev;
   logic wr_en;
   logic [7:0] wdat;
   logic [31:0] rd_nxt;

   function automatic logic choice_valid(input logic [5:0] c);
      case (c)
         6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07: choice_valid = 1'b1;
         6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0F: choice_valid = 1'b1;
         default: choice_valid = 1'b0;
      endcase
   endfunction : choice_valid

   ////////////////////////////////////////////////////////////////////////////
   // AHB address and data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_r <= '0;
      end else if (hready) begin
         acc_r.valid <= hsel & htrans[1];
         acc_r.write <= hwrite;
         acc_r.idx <= haddr[18:2];
      end
   end

   assign wr_en = acc_r.valid & acc_r.write;
   assign wdat = hwdata[7:0];

   // Reads take one wait state so hrdata comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_r <= 1'b0;
         hreadyout <= 1'b1;
      end else if (hready & hsel & htrans[1] & ~hwrite) begin
         rd_wait_r <= 1'b1;
         hreadyout <= 1'b0;
      end else begin
         rd_wait_r <= 1'b0;
         hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   always_comb begin
      rd_nxt = 32'h00000000;
      case (acc_r.idx)
         `POCFG_IDX_SEL2: rd_nxt[7:0] = sel_r[2];
         `POCFG_IDX_SEL3: rd_nxt[7:0] = sel_r[3];
         `POCFG_IDX_SEL4: rd_nxt[7:0] = sel_r[4];
         `POCFG_IDX_CDP: rd_nxt[7:0] = cdp_r;
         `POCFG_IDX_GANG: rd_nxt[7:0] = gang_r;
         `POCFG_IDX_CHOICE: rd_nxt[7:0] = choice_r;
         `POCFG_IDX_IRQ_STAT: rd_nxt[7:0] = irq_stat_r;
         `POCFG_IDX_IRQ_MASK: rd_nxt[7:0] = irq_mask_r;
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_wait_r) begin
         hrdata <= rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_r[2] <= `POCFG_RST_SEL;
         sel_r[3] <= `POCFG_RST_SEL;
         sel_r[4] <= `POCFG_RST_SEL;
      end else if (wr_en) begin
         // Whole byte stored, reserved upper nibble is read/write
         if (acc_r.idx == `POCFG_IDX_SEL2) sel_r[2] <= wdat;
         if (acc_r.idx == `POCFG_IDX_SEL3) sel_r[3] <= wdat;
         if (acc_r.idx == `POCFG_IDX_SEL4) sel_r[4] <= wdat;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gang_r <= `POCFG_RST_GANG;
      end else if (wr_en && acc_r.idx == `POCFG_IDX_GANG) begin
         gang_r <= wdat;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         choice_r <= `POCFG_RST_CHOICE;
      end else if (wr_en && acc_r.idx == `POCFG_IDX_CHOICE) begin
         choice_r <= wdat;
      end
   end

   // Handshake flags: hardware set wins over a software write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cdp_r <= `POCFG_RST_CDP;
      end else begin
         cdp_r <= ((wr_en && acc_r.idx == `POCFG_IDX_CDP) ? wdat : cdp_r)
            | {4'h0, port_pins.handshake & {4{~enumerated}}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overcurrent source selection and ganging
   assign src[0] = `POCFG_SRC_PIN;
   assign src[1] = sel_r[2][`POCFG_SEL_MSB:`POCFG_SEL_LSB];
   assign src[2] = sel_r[3][`POCFG_SEL_MSB:`POCFG_SEL_LSB];
   assign src[3] = sel_r[4][`POCFG_SEL_MSB:`POCFG_SEL_LSB];
   assign gang_en = gang_r[`POCFG_GANG_MSB:`POCFG_GANG_LSB];
   assign choice_ok = choice_valid(choice_r[`POCFG_CHOICE_MSB:0]);
   assign gang_any = |(raw_oc & gang_en);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_port
         logic raw_bit;
         // One process per port drives its own local bit only
         always_comb begin
            case (src[gi])
               `POCFG_SRC_OFF: raw_bit = 1'b0;
               `POCFG_SRC_PIN: raw_bit = port_pins.sense[gi];
               `POCFG_SRC_GPIO: raw_bit = port_pins.gpio[gi];
               `POCFG_SRC_FORCE: raw_bit = 1'b1;
               default: raw_bit = 1'b0;
            endcase
         end
         assign raw_oc[gi] = raw_bit;
         // Ganged port sees any ganged fault, or the shared pin when the pin choice is valid
         assign oc_nxt[gi] = raw_oc[gi]
            | (gang_en[gi] & (gang_any | (choice_ok & shared_fault_in)));
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_overcurrent <= 4'h0;
         port_disabled <= 4'h0;
      end else begin
         port_overcurrent <= oc_nxt;
         for (int i = 0; i < 4; i++) begin
            port_disabled[i] <= (src[i] == `POCFG_SRC_OFF);
         end
      end
   end

   // Shared pin driven only for a valid choice
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shared_fault_out <= 1'b0;
         shared_fault_oe <= 1'b0;
         shared_fault_pin_choice <= 6'h00;
      end else begin
         shared_fault_out <= gang_any;
         shared_fault_oe <= choice_ok & gang_any;
         shared_fault_pin_choice <= choice_r[`POCFG_CHOICE_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: overcurrent rise and handshake flag set
   assign irq_ev = {port_pins.handshake & {4{~enumerated}} & ~cdp_r[3:0],
                    oc_nxt & ~port_overcurrent};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_r <= `POCFG_RST_IRQ;
      end else begin
         irq_stat_r <= (irq_stat_r
            & ~((wr_en && acc_r.idx == `POCFG_IDX_IRQ_STAT) ? wdat : 8'h00)) | irq_ev;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_r <= `POCFG_RST_IRQ;
      end else if (wr_en && acc_r.idx == `POCFG_IDX_IRQ_MASK) begin
         irq_mask_r <= wdat;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

endmodule : pocfg_top

//--- pocfg_top_monitor.sv
// Checker for the overcurrent bank: shadows bus writes, checks port outputs.
// Assumes one hclk domain and single word AHB-Lite transfers.
`timescale 1ns/1ps
`include "pocfg_params.svh"
module pocfg_top_monitor (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] haddr,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic [1:0] htrans,
   // Port side
   input wire pocfg_pkg::pocfg_pins_s port_pins,
   input wire logic [3:0] port_overcurrent,
   input wire logic [3:0] port_disabled,
   // Shared fault pin
   input wire logic shared_fault_in,
   input wire logic shared_fault_out,
   input wire logic shared_fault_oe,
   input wire logic [5:0] shared_fault_pin_choice
);
   import pocfg_pkg::*;
   logic wp, vld, ho, oek, frc, ng;
   logic [16:0] wi;
   logic [7:0] s2, s3, s4, gg, ch;
   logic [3:0] own, xp;
   logic [2:0] z;
   function automatic logic src(input logic [7:0] r, input logic s, input logic g);
      case (r[3:0])
         4'h1: return s;
         4'h2: return g;
         4'hF: return 1'h1;
         default: return 1'h0;
      endcase
   endfunction : src
   // Shadow of the written select, gang and choice registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp <= 1'h0;
         wi <= '0;
         s2 <= '0;
         s3 <= '0;
         s4 <= '0;
         gg <= '0;
         ch <= '0;
      end else if (hready) begin
         wp <= hsel && htrans[1] && hwrite;
         wi <= haddr[18:2];
         if (wp && wi == `POCFG_IDX_SEL2) s2 <= hwdata[7:0];
         if (wp && wi == `POCFG_IDX_SEL3) s3 <= hwdata[7:0];
         if (wp && wi == `POCFG_IDX_SEL4) s4 <= hwdata[7:0];
         if (wp && wi == `POCFG_IDX_GANG) gg <= hwdata[7:0];
         if (wp && wi == `POCFG_IDX_CHOICE) ch <= hwdata[7:0];
      end
   end
   assign own = {src(s4, port_pins.sense[3], port_pins.gpio[3]),
      src(s3, port_pins.sense[2], port_pins.gpio[2]),
      src(s2, port_pins.sense[1], port_pins.gpio[1]), port_pins.sense[0]};
   assign ho = |(own & gg[4:1]);
   assign vld = ch[5:0] inside {6'h0, 6'h1, 6'h3, [6'h4:6'hB], 6'hF};
   assign oek = vld & ho;
   assign xp = own | (gg[4:1] & {4{ho | (vld & shared_fault_in)}});
   assign z = {s4[3:0] == 4'h0, s3[3:0] == 4'h0, s2[3:0] == 4'h0};
   assign frc = s2[3:0] == 4'hF;
   assign ng = gg[4:1] == 4'h0;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////
   property p_upper; hreadyout |-> hrdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("read upper bits set");
   property p_dis; $past(hresetn) |-> port_disabled == {$past(z), 1'h0}; endproperty
   a_dis: assert property (p_dis) else $error("disable flags wrong");
   property p_own; $past(hresetn) && $past(ng) |-> port_overcurrent == $past(own); endproperty
   a_own: assert property (p_own) else $error("source select wrong");
   property p_frc; $past(hresetn) && $past(frc) |-> port_overcurrent[1]; endproperty
   a_frc: assert property (p_frc) else $error("forced fault missing");
   property p_sout; $past(hresetn) |-> shared_fault_out == $past(ho); endproperty
   a_sout: assert property (p_sout) else $error("shared out wrong");
   property p_ch; $past(hresetn) |-> shared_fault_pin_choice == $past(ch[5:0]); endproperty
   a_ch: assert property (p_ch) else $error("pin choice wrong");
   property p_oe; $past(hresetn) |-> shared_fault_oe == $past(oek); endproperty
   a_oe: assert property (p_oe) else $error("shared enable wrong");
   property p_gang; $past(hresetn) |-> port_overcurrent == $past(xp); endproperty
   a_gang: assert property (p_gang) else $error("ganged fault wrong");
endmodule : pocfg_top_monitor
bind pocfg_top pocfg_top_monitor u_mon (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout,
   .haddr, .hwdata, .hrdata, .htrans, .port_pins, .port_overcurrent, .port_disabled,
   .shared_fault_in, .shared_fault_out, .shared_fault_oe, .shared_fault_pin_choice);

//--- pocfg_top_tb_top.sv
// Self-checking bench for the overcurrent bank.
// Assumes the monitor is bound and hready is looped from hreadyout.
`timescale 1ns/1ps
`include "pocfg_params.svh"
module pocfg_top_tb_top;
   import pocfg_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, shared_fault_in = 0, enumerated = 0;
   logic [31:0] haddr = '0, hwdata = '0;
   logic [1:0] htrans = '0;
   pocfg_pins_s port_pins = '0;
   wire logic hreadyout, hresp, shared_fault_out, shared_fault_oe, irq;
   wire logic [31:0] hrdata;
   wire logic [3:0] port_overcurrent, port_disabled;
   wire logic [5:0] shared_fault_pin_choice;
   int failures = 0, samples_checked = 0, cyc = 0;
   always #2.5 hclk = ~hclk;
   pocfg_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .port_pins, .enumerated,
      .port_overcurrent, .port_disabled, .shared_fault_in, .shared_fault_out,
      .shared_fault_oe, .shared_fault_pin_choice, .irq);
   ////////////////////////////////////////
   task automatic end_of_test;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         failures++;
         end_of_test;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic [16:0] i, input logic w, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= {13'h0, i, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
   endtask : bus
   task automatic wr(input logic [16:0] i, input logic [7:0] d);
      bus(i, 1'h1, d);
   endtask : wr
   task automatic rd(input logic [16:0] i, input logic [7:0] e);
      bus(i, 1'h0, 8'h0);
      chk(hrdata, {24'h0, e});
      chk(32'(hresp), 32'h0);
   endtask : rd
   task automatic pins(input logic [3:0] s, input logic [3:0] g, input logic [3:0] h);
      @(posedge hclk);
      port_pins <= {s, g, h};
   endtask : pins
   task automatic st;
      repeat (3) @(posedge hclk);
   endtask : st
   task automatic t_src;
      logic [3:0] cs [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
      logic [3:0] c, m;
      logic [16:0] a;
      for (int k = 0; k < 3; k++) begin
         m = 4'h2 << k;
         a = 17'(`POCFG_IDX_SEL2 + 4 * k);
         for (int j = 0; j < 4; j++) begin
            c = cs[j];
            wr(a, {4'hA, c});
            rd(a, {4'hA, c});
            pins(m, 4'h0, 4'h0);
            st;
            chk(32'(port_overcurrent), 32'((c == 4'h1 || c == 4'hF) ? m : 4'h0));
            chk(32'(port_disabled), 32'(c == 4'h0 ? 4'hE : 4'hE & ~m));
            pins(4'h0, m, 4'h0);
            st;
            chk(32'(port_overcurrent), 32'((c == 4'h2 || c == 4'hF) ? m : 4'h0));
         end
         wr(a, 8'h00);
      end
      rd(17'h00100, 8'h00);
      $display("source select test done");
   endtask : t_src
   task automatic t_cdp;
      pins(4'h0, 4'h0, 4'h4);
      pins(4'h0, 4'h0, 4'h0);
      st;
      rd(`POCFG_IDX_CDP, 8'h04);
      chk(32'(irq), 32'h0);
      wr(`POCFG_IDX_IRQ_MASK, 8'h40);
      st;
      chk(32'(irq), 32'h1);
      wr(`POCFG_IDX_IRQ_STAT, 8'h40);
      st;
      chk(32'(irq), 32'h0);
      @(posedge hclk) enumerated <= 1;
      pins(4'h0, 4'h0, 4'h1);
      pins(4'h0, 4'h0, 4'h0);
      st;
      rd(`POCFG_IDX_CDP, 8'h04);
      wr(`POCFG_IDX_CDP, 8'h00);
      rd(`POCFG_IDX_CDP, 8'h00);
      $display("handshake flag test done");
   endtask : t_cdp
   task automatic t_gang;
      wr(`POCFG_IDX_IRQ_STAT, 8'hFF);
      wr(`POCFG_IDX_SEL2, 8'h01);
      wr(`POCFG_IDX_SEL3, 8'h01);
      wr(`POCFG_IDX_GANG, 8'h06);
      wr(`POCFG_IDX_CHOICE, 8'h01);
      pins(4'h1, 4'h0, 4'h0);
      st;
      chk(32'(port_overcurrent), 32'h3);
      rd(`POCFG_IDX_IRQ_STAT, 8'h03);
      wr(`POCFG_IDX_IRQ_MASK, 8'h03);
      st;
      chk(32'(irq), 32'h1);
      chk(32'({shared_fault_oe, shared_fault_out, shared_fault_pin_choice}), 32'hC1);
      wr(`POCFG_IDX_CHOICE, 8'h02);
      st;
      chk(32'({shared_fault_oe, shared_fault_pin_choice}), 32'h02);
      wr(`POCFG_IDX_CHOICE, 8'h03);
      pins(4'h0, 4'h0, 4'h0);
      @(posedge hclk) shared_fault_in <= 1;
      st;
      chk(32'(port_overcurrent), 32'h3);
      $display("gang test done");
   endtask : t_gang
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      t_src;
      t_cdp;
      t_gang;
      end_of_test;
   end
endmodule : pocfg_top_tb_top
